// [shared/pdf_pkg.sv]
// Constants and types shared by the position-done and fly-move block
package pdf_pkg;

    // Register byte addresses on the plain register port
    localparam logic [7:0] ADDR_UNIT_SEL   = 8'h00;
    localparam logic [7:0] ADDR_DONE_COND  = 8'h04;
    localparam logic [7:0] ADDR_DONE_THR   = 8'h08;
    localparam logic [7:0] ADDR_NEAR_THR   = 8'h0c;
    localparam logic [7:0] ADDR_TIME_THR   = 8'h10;
    localparam logic [7:0] ADDR_HOLD_TIME  = 8'h14;
    localparam logic [7:0] ADDR_FLY_EN     = 8'h18;
    localparam logic [7:0] ADDR_FLY_DISP   = 8'h1c;
    localparam logic [7:0] ADDR_FLY_SPEED  = 8'h20;
    localparam logic [7:0] ADDR_FLY_UNLOCK = 8'h24;
    localparam logic [7:0] ADDR_EDGE_LOGIC = 8'h28;
    localparam logic [7:0] ADDR_REF_COUNT  = 8'h2c;
    localparam logic [7:0] ADDR_STATUS     = 8'h30;

    // Reset values
    localparam logic        RST_UNIT_SEL   = 1'b0;
    localparam logic [1:0]  RST_DONE_COND  = 2'h0;
    localparam logic [15:0] RST_DONE_THR   = 16'h02de;
    localparam logic [15:0] RST_NEAR_THR   = 16'hffff;
    localparam logic [15:0] RST_TIME_THR   = 16'h0000;
    localparam logic [15:0] RST_HOLD_TIME  = 16'h0000;
    localparam logic        RST_FLY_EN     = 1'b0;
    localparam logic [31:0] RST_FLY_DISP   = 32'h0000_2710;
    localparam logic [15:0] RST_FLY_SPEED  = 16'h00c8;
    localparam logic        RST_FLY_UNLOCK = 1'b1;
    localparam logic [2:0]  RST_EDGE_LOGIC = 3'h0;

    // Setting limits
    localparam logic [15:0] THR_MIN        = 16'h0001;
    localparam logic [15:0] TIME_MAX_MS    = 16'h7530;
    localparam logic [15:0] MIN_SPEED_RPM  = 16'h000a;

    // Output condition codes
    localparam logic [1:0]  COND_PLAIN     = 2'h0;
    localparam logic [1:0]  COND_FILTERED  = 2'h1;
    localparam logic [1:0]  COND_RAW_REF   = 2'h2;
    localparam logic [1:0]  COND_HOLD      = 2'h3;

    // Trigger edge logic codes
    localparam logic [2:0]  EDGE_FALL_A    = 3'h0;
    localparam logic [2:0]  EDGE_RISE_A    = 3'h1;
    localparam logic [2:0]  EDGE_RISE_B    = 3'h2;
    localparam logic [2:0]  EDGE_FALL_B    = 3'h3;
    localparam logic [2:0]  EDGE_BOTH      = 3'h4;

    // Millisecond tick timing
    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned TICK_PERIOD_NS = 1000000;
    localparam int unsigned MS_TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // Fly-move sequencer states
    typedef enum logic [1:0] {
        FLY_IDLE,
        FLY_RUN,
        FLY_LOCK
    } pdf_fly_t;

endpackage

// [hdl/pdf_top.sv]
// Position done/near status and fixed-length fly move for a servo drive
`timescale 1ns/1ps

module pdf_top #(
    parameter int unsigned TICK_CYCLES = pdf_pkg::MS_TICK_CYCLES
) (
    input  wire logic               CLK,
    input  wire logic               RST,
    input  wire logic [7:0]         REG_ADDR,
    input  wire logic [31:0]        REG_WDATA,
    input  wire logic               REG_WR,
    input  wire logic               REG_RD,
    output logic [31:0]             REG_RDATA,
    input  wire logic               SERVO_ON,
    input  wire logic               POS_MODE,
    input  wire logic               HOMING_ACTIVE,
    input  wire logic signed [31:0] CMD_POS_ENC,
    input  wire logic signed [31:0] FB_POS_ENC,
    input  wire logic signed [31:0] CMD_POS_REF,
    input  wire logic signed [31:0] FB_POS_REF,
    input  wire logic signed [15:0] REF_IN_DELTA,
    input  wire logic               REF_FILT_ACTIVE,
    input  wire logic signed [15:0] MOTOR_SPEED,
    input  wire logic               FLY_TRIGGER_IN,
    input  wire logic               FLY_INHIBIT_IN,
    input  wire logic               FLY_UNLOCK_IN,
    input  wire logic signed [15:0] FLY_GEN_DELTA,
    input  wire logic               FLY_GEN_DONE,
    output logic signed [15:0]      REF_OUT_DELTA,
    output logic                    POSITION_DONE_FLAG,
    output logic                    POSITION_NEAR_FLAG,
    output logic                    FLY_MOVE_DONE_FLAG,
    output logic                    FLY_START,
    output logic                    FLY_DIR,
    output logic [31:0]             FLY_DISTANCE,
    output logic [15:0]             FLY_SPEED,
    output logic                    FLY_ACTIVE,
    output logic                    FLY_LOCKED,
    output logic                    MAF_BYPASS
);
    import pdf_pkg::*;

    localparam int DIV_W = $clog2(TICK_CYCLES + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

    typedef struct packed {
        logic               unit_sel;
        logic [1:0]         done_cond;
        logic [15:0]        done_thr;
        logic [15:0]        near_thr;
        logic [15:0]        time_thr;
        logic [15:0]        hold_time;
        logic               fly_en;
        logic [31:0]        fly_disp;
        logic [15:0]        fly_speed;
        logic               fly_unlock;
        logic [2:0]         edge_logic;
        logic [31:0]        ref_count;
        logic [31:0]        rdata;
        logic               trig_s1;
        logic               trig_s2;
        logic               trig_d;
        logic               inh_s1;
        logic               inh_s2;
        logic               unl_s1;
        logic               unl_s2;
        logic [DIV_W-1:0]   div_cnt;
        logic [15:0]        settle_cnt;
        logic [15:0]        hold_cnt;
        logic               hold_latch;
        logic               done_q;
        logic               near_q;
        pdf_fly_t           fly_state;
        logic               fly_done;
        logic               fly_start;
        logic               fly_dir;
        logic [15:0]        fly_run_speed;
        logic signed [15:0] ref_out;
    } pdf_state_t;

    pdf_state_t r_reg;
    pdf_state_t r_next;

    logic               tick;
    logic signed [31:0] dev;
    logic [31:0]        abs_dev;
    logic               active;
    logic               qual;
    logic               raw_done;
    logic               raw_near;
    logic               ready;
    logic               ref_seen;
    logic               rise;
    logic               fall;
    logic               trig_edge;
    logic [15:0]        speed_abs;
    logic               speed_ok;
    logic               accept;
    logic               fly_end;

    // Next-state logic for the whole block
    always_comb begin
        r_next = r_reg;
        r_next.fly_start = 1'b0;

        // Pin synchronisers, first stage read only by the second
        r_next.trig_s1 = FLY_TRIGGER_IN;
        r_next.trig_s2 = r_reg.trig_s1;
        r_next.trig_d  = r_reg.trig_s2;
        r_next.inh_s1  = FLY_INHIBIT_IN;
        r_next.inh_s2  = r_reg.inh_s1;
        r_next.unl_s1  = FLY_UNLOCK_IN;
        r_next.unl_s2  = r_reg.unl_s1;

        tick = (r_reg.div_cnt == DIV_LAST);
        r_next.div_cnt = tick ? '0 : r_reg.div_cnt + 1'b1;

        // Register writes; thresholds held at 1 or more, times capped
        if (REG_WR) begin
            case (REG_ADDR)
                ADDR_UNIT_SEL:   r_next.unit_sel = REG_WDATA[0];
                ADDR_DONE_COND:  r_next.done_cond = REG_WDATA[1:0];
                ADDR_DONE_THR:   r_next.done_thr = (REG_WDATA[15:0] < THR_MIN) ?
                                     THR_MIN : REG_WDATA[15:0];
                ADDR_NEAR_THR:   r_next.near_thr = (REG_WDATA[15:0] < THR_MIN) ?
                                     THR_MIN : REG_WDATA[15:0];
                ADDR_TIME_THR:   r_next.time_thr = (REG_WDATA[15:0] > TIME_MAX_MS) ?
                                     TIME_MAX_MS : REG_WDATA[15:0];
                ADDR_HOLD_TIME:  r_next.hold_time = (REG_WDATA[15:0] > TIME_MAX_MS) ?
                                     TIME_MAX_MS : REG_WDATA[15:0];
                ADDR_FLY_EN:     r_next.fly_en = REG_WDATA[0] & ~HOMING_ACTIVE;
                ADDR_FLY_DISP:   r_next.fly_disp = REG_WDATA;
                ADDR_FLY_SPEED:  r_next.fly_speed = REG_WDATA[15:0];
                ADDR_FLY_UNLOCK: r_next.fly_unlock = REG_WDATA[0];
                ADDR_EDGE_LOGIC: r_next.edge_logic = REG_WDATA[2:0];
                default:         r_next.rdata = r_reg.rdata;
            endcase
        end

        // Read data, one cycle after the strobe; unmapped reads zero
        r_next.rdata = '0;
        if (REG_RD) begin
            case (REG_ADDR)
                ADDR_UNIT_SEL:   r_next.rdata = {31'h0, r_reg.unit_sel};
                ADDR_DONE_COND:  r_next.rdata = {30'h0, r_reg.done_cond};
                ADDR_DONE_THR:   r_next.rdata = {16'h0, r_reg.done_thr};
                ADDR_NEAR_THR:   r_next.rdata = {16'h0, r_reg.near_thr};
                ADDR_TIME_THR:   r_next.rdata = {16'h0, r_reg.time_thr};
                ADDR_HOLD_TIME:  r_next.rdata = {16'h0, r_reg.hold_time};
                ADDR_FLY_EN:     r_next.rdata = {31'h0, r_reg.fly_en};
                ADDR_FLY_DISP:   r_next.rdata = r_reg.fly_disp;
                ADDR_FLY_SPEED:  r_next.rdata = {16'h0, r_reg.fly_speed};
                ADDR_FLY_UNLOCK: r_next.rdata = {31'h0, r_reg.fly_unlock};
                ADDR_EDGE_LOGIC: r_next.rdata = {29'h0, r_reg.edge_logic};
                ADDR_REF_COUNT:  r_next.rdata = r_reg.ref_count;
                ADDR_STATUS:     r_next.rdata = {26'h0, r_reg.hold_latch, r_reg.fly_state,
                                     r_reg.fly_done, r_reg.near_q, r_reg.done_q};
                default:         r_next.rdata = '0;
            endcase
        end

        // unit select picks the deviation source
        // signed difference of command and feedback
        dev     = r_reg.unit_sel ? (CMD_POS_REF - FB_POS_REF) : (CMD_POS_ENC - FB_POS_ENC);
        abs_dev = dev[31] ? 32'(-dev) : 32'(dev);

        active   = SERVO_ON & POS_MODE;
        ref_seen = (REF_IN_DELTA != 16'sh0000);

        // Reference qualification per output condition
        case (r_reg.done_cond)
            COND_PLAIN:    qual = 1'b1;
            COND_FILTERED: qual = ~REF_FILT_ACTIVE;
            COND_RAW_REF:  qual = ~ref_seen;
            COND_HOLD:     qual = ~ref_seen;
            default:       qual = 1'b0;
        endcase

        raw_done = active & qual & (abs_dev < {16'h0, r_reg.done_thr});
        raw_near = active & qual & (abs_dev < {16'h0, r_reg.near_thr});

        // condition must persist for the time threshold
        if (!raw_done) begin
            r_next.settle_cnt = '0;
        end else if (tick && (r_reg.settle_cnt < r_reg.time_thr)) begin
            r_next.settle_cnt = r_reg.settle_cnt + 16'h0001;
        end
        ready = raw_done & (r_reg.settle_cnt >= r_reg.time_thr);

        // holding latch, restarted on each qualified cycle
        if (!active || r_reg.done_cond != COND_HOLD) begin
            r_next.hold_latch = 1'b0;
        end else if (ready) begin
            r_next.hold_latch = 1'b1;
            r_next.hold_cnt   = r_reg.hold_time;
        end else if (r_reg.hold_latch) begin
            if (r_reg.hold_time == 16'h0000) begin
                // zero hold ends on next reference
                if (ref_seen) begin
                    r_next.hold_latch = 1'b0;
                end
            end else if (tick) begin
                r_next.hold_cnt = r_reg.hold_cnt - 16'h0001;
                if (r_reg.hold_cnt <= 16'h0001) begin
                    r_next.hold_latch = 1'b0;
                end
            end
        end

        rise = r_reg.trig_s2 & ~r_reg.trig_d;
        fall = ~r_reg.trig_s2 & r_reg.trig_d;
        case (r_reg.edge_logic)
            EDGE_FALL_A, EDGE_FALL_B: trig_edge = fall;
            EDGE_RISE_A, EDGE_RISE_B: trig_edge = rise;
            EDGE_BOTH:                trig_edge = rise | fall;
            default:                  trig_edge = rise;
        endcase

        speed_abs = MOTOR_SPEED[15] ? 16'(-MOTOR_SPEED) : 16'(MOTOR_SPEED);
        speed_ok  = (r_reg.fly_speed != 16'h0000) | (speed_abs >= MIN_SPEED_RPM);
        // homing and inhibit block the trigger
        accept = trig_edge & r_reg.fly_en & ~HOMING_ACTIVE & active & ~r_reg.inh_s2 &
                 (r_reg.fly_disp != 32'h0) & speed_ok;

        fly_end = 1'b0;
        r_next.ref_out = 16'sh0000;
        case (r_reg.fly_state)
            FLY_IDLE: begin
                if (accept) begin
                    r_next.fly_state     = FLY_RUN;
                    r_next.fly_start     = 1'b1;
                    r_next.fly_dir       = MOTOR_SPEED[15];
                    r_next.fly_run_speed = (r_reg.fly_speed != 16'h0000) ?
                                           r_reg.fly_speed : speed_abs;
                    r_next.fly_done      = 1'b0;
                end else begin
                    r_next.ref_out   = REF_IN_DELTA;
                    r_next.ref_count = r_reg.ref_count + 32'(REF_IN_DELTA);
                    if (ref_seen) begin
                        r_next.fly_done = 1'b0;
                    end
                end
            end
            FLY_RUN: begin
                // only the move reference passes and counts
                r_next.ref_out   = FLY_GEN_DELTA;
                r_next.ref_count = r_reg.ref_count + 32'(FLY_GEN_DELTA);
                if (FLY_GEN_DONE) begin
                    fly_end         = 1'b1;
                    r_next.fly_done = 1'b1;
                    // lock or release per unlock setting
                    r_next.fly_state = r_reg.fly_unlock ? FLY_LOCK : FLY_IDLE;
                end else if (!active) begin
                    r_next.fly_state = FLY_IDLE;
                end
            end
            FLY_LOCK: begin
                if (r_reg.unl_s2) begin
                    r_next.fly_state = FLY_IDLE;
                end
            end
            default: r_next.fly_state = FLY_IDLE;
        endcase

        // outputs gated by servo on, done forced at move end
        r_next.done_q = active & (ready | r_reg.hold_latch | fly_end);
        r_next.near_q = active & (raw_near | r_reg.hold_latch | fly_end);
    end

    // State register
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            r_reg            <= '0;
            r_reg.unit_sel   <= RST_UNIT_SEL;
            r_reg.done_cond  <= RST_DONE_COND;
            r_reg.done_thr   <= RST_DONE_THR;
            r_reg.near_thr   <= RST_NEAR_THR;
            r_reg.time_thr   <= RST_TIME_THR;
            r_reg.hold_time  <= RST_HOLD_TIME;
            r_reg.fly_en     <= RST_FLY_EN;
            r_reg.fly_disp   <= RST_FLY_DISP;
            r_reg.fly_speed  <= RST_FLY_SPEED;
            r_reg.fly_unlock <= RST_FLY_UNLOCK;
            r_reg.edge_logic <= RST_EDGE_LOGIC;
            r_reg.fly_state  <= FLY_IDLE;
        end else begin
            r_reg <= r_next;
        end
    end

    // Outputs straight from the state register
    assign REG_RDATA          = r_reg.rdata;
    assign REF_OUT_DELTA      = r_reg.ref_out;
    assign POSITION_DONE_FLAG = r_reg.done_q;
    assign POSITION_NEAR_FLAG = r_reg.near_q;
    assign FLY_MOVE_DONE_FLAG = r_reg.fly_done;
    assign FLY_START          = r_reg.fly_start;
    assign FLY_DIR            = r_reg.fly_dir;
    assign FLY_DISTANCE       = r_reg.fly_disp;
    assign FLY_SPEED          = r_reg.fly_run_speed;
    assign FLY_ACTIVE         = (r_reg.fly_state == FLY_RUN);
    assign FLY_LOCKED         = (r_reg.fly_state == FLY_LOCK);
    assign MAF_BYPASS         = r_reg.fly_en;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    sequence move_running_s;
        r_reg.fly_state == FLY_RUN;
    endsequence
    sequence move_ends_s;
        move_running_s ##0 FLY_GEN_DONE && SERVO_ON && POS_MODE;
    endsequence

    servo_off_clear_a: assert property (!SERVO_ON |=> !POSITION_DONE_FLAG && !POSITION_NEAR_FLAG)
        else $error("done or near high after servo off");
    pos_mode_only_a: assert property (!POS_MODE |=> !POSITION_DONE_FLAG)
        else $error("done high outside position mode");
    fly_done_pair_a: assert property (move_ends_s |=> FLY_MOVE_DONE_FLAG && POSITION_DONE_FLAG)
        else $error("fly done and done not together");
    homing_block_a: assert property (FLY_START |-> $past(!HOMING_ACTIVE))
        else $error("fly move started during homing");
    inhibit_block_a: assert property (FLY_START |-> $past(!r_reg.inh_s2))
        else $error("fly move started while inhibited");
    speed_gate_a: assert property (FLY_START |-> $past(speed_ok) && FLY_DISTANCE != 32'h0)
        else $error("fly move started without speed or displacement");
    run_count_a: assert property (move_running_s |=>
                     r_reg.ref_count == $past(r_reg.ref_count) + 32'($past(FLY_GEN_DELTA)))
        else $error("counter took a foreign reference during move");
    lock_holds_a: assert property (FLY_LOCKED && !r_reg.unl_s2 |=> FLY_LOCKED)
        else $error("lock left without unlock input");
    plain_near_a: assert property (SERVO_ON && POS_MODE && r_reg.done_cond == COND_PLAIN &&
                     abs_dev < {16'h0, r_reg.near_thr} |=> POSITION_NEAR_FLAG)
        else $error("near missing under plain condition");
    raw_ref_block_a: assert property (r_reg.done_cond == COND_RAW_REF && ref_seen &&
                     r_reg.fly_state != FLY_RUN && !r_reg.hold_latch |=> !POSITION_DONE_FLAG)
        else $error("done high with reference input active");
    bypass_follow_a: assert property (r_reg.fly_en |-> MAF_BYPASS)
        else $error("filter not bypassed");

endmodule

// [dv/pdf_gen_model.sv]
// Profile generator model that plays out a fixed-length move on request
`timescale 1ns/1ps

module pdf_gen_model (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          start,
    input  wire logic [7:0]    len,
    output logic signed [15:0] delta,
    output logic               done
);
    logic [7:0] cnt_reg;

    // Fixed step every cycle of the move, then a one-cycle finish pulse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 8'h00;
            delta   <= 16'sh0000;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                cnt_reg <= len;
                delta   <= 16'sh0003;
            end else if (cnt_reg > 8'h01) begin
                cnt_reg <= cnt_reg - 8'h01;
            end else if (cnt_reg == 8'h01) begin
                cnt_reg <= 8'h00;
                delta   <= 16'sh0000; // No reference outside the move
                done    <= 1'b1;
            end
        end
    end
endmodule

// [dv/testbench.sv]
// Self-checking testbench for the position-done and fly-move block
`timescale 1ns/1ps

module testbench;
    import pdf_pkg::*;
    localparam int unsigned TICK = 4;
    localparam int unsigned LEN = 8;
    logic CLK, RST, REG_WR, REG_RD, SERVO_ON, POS_MODE, HOMING_ACTIVE, REF_FILT_ACTIVE;
    logic FLY_TRIGGER_IN, FLY_INHIBIT_IN, FLY_UNLOCK_IN, FLY_GEN_DONE, FLY_START, FLY_DIR;
    logic POSITION_DONE_FLAG, POSITION_NEAR_FLAG, FLY_MOVE_DONE_FLAG;
    logic FLY_ACTIVE, FLY_LOCKED, MAF_BYPASS;
    logic [7:0] REG_ADDR;
    logic [31:0] REG_WDATA, REG_RDATA, FLY_DISTANCE, c0, c1;
    logic [15:0] FLY_SPEED;
    logic signed [31:0] CMD_POS_ENC, FB_POS_ENC, CMD_POS_REF, FB_POS_REF;
    logic signed [15:0] REF_IN_DELTA, MOTOR_SPEED, FLY_GEN_DELTA, REF_OUT_DELTA, run_ref;
    logic done_at_end;
    int n_fail = 0;
    int num_checks = 0;

    pdf_top #(.TICK_CYCLES(TICK)) dut_u (.CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .SERVO_ON(SERVO_ON), .POS_MODE(POS_MODE), .HOMING_ACTIVE(HOMING_ACTIVE),
        .CMD_POS_ENC(CMD_POS_ENC), .FB_POS_ENC(FB_POS_ENC), .CMD_POS_REF(CMD_POS_REF),
        .FB_POS_REF(FB_POS_REF), .REF_IN_DELTA(REF_IN_DELTA), .REF_FILT_ACTIVE(REF_FILT_ACTIVE),
        .MOTOR_SPEED(MOTOR_SPEED), .FLY_TRIGGER_IN(FLY_TRIGGER_IN),
        .FLY_INHIBIT_IN(FLY_INHIBIT_IN), .FLY_UNLOCK_IN(FLY_UNLOCK_IN),
        .FLY_GEN_DELTA(FLY_GEN_DELTA), .FLY_GEN_DONE(FLY_GEN_DONE), .REF_OUT_DELTA(REF_OUT_DELTA),
        .POSITION_DONE_FLAG(POSITION_DONE_FLAG), .POSITION_NEAR_FLAG(POSITION_NEAR_FLAG),
        .FLY_MOVE_DONE_FLAG(FLY_MOVE_DONE_FLAG), .FLY_START(FLY_START), .FLY_DIR(FLY_DIR),
        .FLY_DISTANCE(FLY_DISTANCE), .FLY_SPEED(FLY_SPEED), .FLY_ACTIVE(FLY_ACTIVE),
        .FLY_LOCKED(FLY_LOCKED), .MAF_BYPASS(MAF_BYPASS));

    pdf_gen_model gen_u (.clk(CLK), .rst(RST), .start(FLY_START), .len(8'(LEN)),
        .delta(FLY_GEN_DELTA), .done(FLY_GEN_DONE));

    // Clock and watchdog
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    initial begin
        #200000;
        n_fail++;
        finish_test();
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge CLK);
        REG_WR <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge CLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CLK);
        REG_RD <= 1'b0;
        #1;
        d = REG_RDATA;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(d, exp);
    endtask
    // Apply {unit, cond, servo, mode, filtered, raw ref} and compare done/near
    task automatic dcase(input logic [6:0] v, input logic [1:0] exp);
        wr(ADDR_UNIT_SEL, {31'h0, v[6]});
        wr(ADDR_DONE_COND, {30'h0, v[5:4]});
        @(posedge CLK);
        {SERVO_ON, POS_MODE, REF_FILT_ACTIVE} <= v[3:1];
        REF_IN_DELTA <= v[0] ? 16'sh0005 : 16'sh0000;
        repeat (5) @(posedge CLK);
        #1;
        // host reads done and near terminals
        chk({30'h0, POSITION_DONE_FLAG, POSITION_NEAR_FLAG}, {30'h0, exp});
    endtask
    // Move the trigger pin, report a start and what done showed at move end
    task automatic ftrig(input logic v, input logic exp);
        logic got, pf;
        @(posedge CLK);
        FLY_TRIGGER_IN <= v;
        got = 1'b0;
        #1;
        pf = FLY_MOVE_DONE_FLAG;
        repeat (30) begin
            @(posedge CLK);
            #1;
            got |= FLY_START;
            if (FLY_ACTIVE && REF_OUT_DELTA !== 16'sh0000) run_ref = REF_OUT_DELTA;
            if (FLY_MOVE_DONE_FLAG && !pf) done_at_end = POSITION_DONE_FLAG;
            pf = FLY_MOVE_DONE_FLAG;
        end
        chk({31'h0, got}, {31'h0, exp});
    endtask
    task automatic finish_test;
        $display("checks=%0d mismatches=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        {REG_WR, REG_RD, SERVO_ON, POS_MODE, HOMING_ACTIVE, REF_FILT_ACTIVE} = '0;
        {FLY_TRIGGER_IN, FLY_INHIBIT_IN, FLY_UNLOCK_IN, REG_ADDR, REG_WDATA} = '0;
        {CMD_POS_ENC, FB_POS_ENC, FB_POS_REF, REF_IN_DELTA} = '0;
        CMD_POS_ENC = 32'sd100;
        CMD_POS_REF = 32'sd900;
        MOTOR_SPEED = -16'sd20;
        RST = 1'b1;
        repeat (20) @(posedge CLK);
        RST <= 1'b0;
        rchk(ADDR_DONE_THR, 32'h2de);
        rchk(ADDR_NEAR_THR, 32'hffff);
        rchk(ADDR_HOLD_TIME, 32'h0);
        rchk(ADDR_UNIT_SEL, 32'h0);
        rchk(8'h3c, 32'h0);
        wr(ADDR_DONE_THR, 32'h0);
        rchk(ADDR_DONE_THR, 32'h1);
        wr(ADDR_TIME_THR, 32'h9999);
        rchk(ADDR_TIME_THR, 32'h7530);
        wr(ADDR_TIME_THR, 32'h0);
        wr(ADDR_DONE_THR, 32'h2de);
        wr(ADDR_NEAR_THR, 32'h3e8);
        $display("test registers done");
        dcase(7'b0001100, 2'b11);
        dcase(7'b0001111, 2'b11);
        dcase(7'b1001100, 2'b01);
        dcase(7'b0011110, 2'b00);
        dcase(7'b0011101, 2'b11);
        dcase(7'b0101101, 2'b00);
        dcase(7'b0101110, 2'b11);
        dcase(7'b0000100, 2'b00);
        dcase(7'b0001000, 2'b00);
        wr(ADDR_HOLD_TIME, 32'h2);
        dcase(7'b0111100, 2'b11);
        @(posedge CLK);
        CMD_POS_ENC <= 32'sd5000;
        repeat (3) @(posedge CLK);
        #1;
        chk({31'h0, POSITION_DONE_FLAG}, 32'h1);
        repeat (16) @(posedge CLK);
        #1;
        chk({31'h0, POSITION_DONE_FLAG}, 32'h0);
        wr(ADDR_HOLD_TIME, 32'h0);
        CMD_POS_ENC <= 32'sd100;
        repeat (4) @(posedge CLK);
        CMD_POS_ENC <= 32'sd5000;
        repeat (12) @(posedge CLK);
        #1;
        chk({31'h0, POSITION_DONE_FLAG}, 32'h1);
        @(posedge CLK);
        REF_IN_DELTA <= 16'sh0005;
        @(posedge CLK);
        REF_IN_DELTA <= 16'sh0000;
        repeat (4) @(posedge CLK);
        #1;
        chk({31'h0, POSITION_DONE_FLAG}, 32'h0);
        wr(ADDR_DONE_COND, 32'h0);
        wr(ADDR_TIME_THR, 32'h3);
        CMD_POS_ENC <= 32'sd100;
        repeat (4) @(posedge CLK);
        #1;
        chk({31'h0, POSITION_DONE_FLAG}, 32'h0);
        repeat (16) @(posedge CLK);
        #1;
        chk({31'h0, POSITION_DONE_FLAG}, 32'h1);
        wr(ADDR_TIME_THR, 32'h0);
        CMD_POS_ENC <= 32'sd5000;
        $display("test done and near done");
        wr(ADDR_FLY_EN, 32'h1);
        wr(ADDR_EDGE_LOGIC, 32'h1);
        rchk(ADDR_FLY_EN, 32'h1);
        chk({31'h0, MAF_BYPASS}, 32'h1);
        rd(ADDR_REF_COUNT, c0);
        ftrig(1'b1, 1'b1);
        chk({31'h0, FLY_DIR}, 32'h1);
        chk({31'h0, done_at_end}, 32'h1);
        chk({16'h0, run_ref}, 32'h3);
        chk({31'h0, FLY_LOCKED}, 32'h1);
        chk({16'h0, FLY_SPEED}, {16'h0, RST_FLY_SPEED});
        chk(FLY_DISTANCE, RST_FLY_DISP);
        rchk(ADDR_STATUS, 32'h14);
        rd(ADDR_REF_COUNT, c1);
        chk(c1, c0 + 32'(3 * LEN));
        ftrig(1'b0, 1'b0);
        // Host frees the block for new references
        @(posedge CLK);
        FLY_UNLOCK_IN <= 1'b1;
        repeat (8) @(posedge CLK);
        #1;
        chk({31'h0, FLY_LOCKED}, 32'h0);
        @(posedge CLK);
        FLY_UNLOCK_IN <= 1'b0;
        $display("test fly move done");
        wr(ADDR_FLY_UNLOCK, 32'h0);
        MOTOR_SPEED <= 16'sd20;
        for (int c = 0; c < 5; c++) begin
            wr(ADDR_EDGE_LOGIC, 32'(c));
            repeat (2) ftrig(~FLY_TRIGGER_IN, (c == 4) || ((c == 1 || c == 2) == !FLY_TRIGGER_IN));
        end
        @(posedge CLK);
        FLY_INHIBIT_IN <= 1'b1;
        ftrig(~FLY_TRIGGER_IN, 1'b0);
        @(posedge CLK);
        FLY_INHIBIT_IN <= 1'b0;
        wr(ADDR_FLY_SPEED, 32'h0);
        MOTOR_SPEED <= 16'sd5;
        ftrig(~FLY_TRIGGER_IN, 1'b0);
        @(posedge CLK);
        MOTOR_SPEED <= 16'sd10;
        ftrig(~FLY_TRIGGER_IN, 1'b1);
        chk({16'h0, FLY_SPEED}, 32'ha);
        chk({31'h0, FLY_DIR}, 32'h0);
        wr(ADDR_FLY_DISP, 32'h0);
        ftrig(~FLY_TRIGGER_IN, 1'b0);
        wr(ADDR_FLY_EN, 32'h0);
        HOMING_ACTIVE <= 1'b1;
        wr(ADDR_FLY_EN, 32'h1);
        rchk(ADDR_FLY_EN, 32'h0);
        $display("test fly gating done");
        finish_test();
    end
endmodule
